/* hw/cbs_cfg.svh */
// Constants of the clock-buffer configuration bank and its SMBus host.
`ifndef CBS_CFG_SVH
`define CBS_CFG_SVH
// ***************************************************************
// Link parameters
// ***************************************************************
`define CBS_SLV_ADDR    7'h2A
`define CBS_CLK_NS      10
`define CBS_SMB_NS      10000
`define CBS_QTR         ((`CBS_SMB_NS + 4 * `CBS_CLK_NS - 1) / (4 * `CBS_CLK_NS))
// ***************************************************************
// Mode codes and device register map
// ***************************************************************
`define CBS_MODE_LOBW   2'h0
`define CBS_MODE_BYP    2'h1
`define CBS_MODE_HIBW   2'h3
`define CBS_MODE_RST    2'h3
`define CBS_REG_PLL     8'h00
`define CBS_REG_OE_LO   8'h01
`define CBS_REG_OE_HI   8'h02
`define CBS_REG_RSV3    8'h03
`define CBS_REG_RSV4    8'h04
`define CBS_REG_ID      8'h05
`define CBS_REG_DEV     8'h06
`define CBS_REG_BC      8'h07
`define CBS_REG_RSV8    8'h08
`define CBS_SW_EN_BIT   3
`define CBS_R0_RSVD     8'h01
`define CBS_R1_RSVD     8'h99
`define CBS_R2_RSVD     8'h08
`define CBS_RSVD_ZERO   8'h00
`define CBS_SW_EN_RST   1'b0
`define CBS_SW_MODE_RST 2'h3
`define CBS_OE_RST      6'h3F
`define CBS_BC_RST      5'h08
// Identification values are arbitrary.
`define CBS_REV_CODE    4'h3
`define CBS_VEN_CODE    4'h5
`define CBS_DEV_CODE    8'h5A
// ***************************************************************
// Host register map
// ***************************************************************
`define CBS_H_CTRL      8'h00
`define CBS_H_STAT      8'h04
`define CBS_H_DATA      2'h1
`define CBS_OKAY        2'h0
`define CBS_SLVERR      2'h2
`endif

/* hw/cbs_pkg.sv */
// Types shared by both ends of the configuration link.
package cbs_pkg;
	typedef enum logic [4:0] {
		D_IDLE = 5'h01,
		D_RX   = 5'h02,
		D_RACK = 5'h04,
		D_TX   = 5'h08,
		D_TACK = 5'h10
	} cbs_dst_type;

	typedef enum logic [3:0] {
		H_IDLE  = 4'h1,
		H_START = 4'h2,
		H_BIT   = 4'h4,
		H_STOP  = 4'h8
	} cbs_hst_type;

	typedef struct packed {
		cbs_dst_type st;
		logic        scl_p;
		logic        sda_p;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic [1:0]  phase;
		logic        rd;
		logic        mack;
		logic [7:0]  idx;
		logic        sda_o;
		logic        sda_oen;
		logic        sw_en;
		logic [1:0]  sw_mode;
		logic [5:0]  oe;
		logic [4:0]  bc;
		logic [1:0]  lat_mode;
		logic        latched;
		logic [1:0]  pll_mode;
		logic [5:0]  out_en;
	} cbs_dev_type;

	typedef struct packed {
		cbs_hst_type     st;
		logic [7:0]      qc;
		logic [1:0]      q;
		logic [3:0]      bitn;
		logic [5:0]      bno;
		logic            rdph;
		logic            rd;
		logic [7:0]      sh;
		logic            nack;
		logic            busy;
		logic            err;
		logic [7:0]      idx;
		logic [4:0]      cnt;
		logic [7:0]      bcnt_rx;
		logic [15:0][7:0] buf_d;
		logic            scl_o;
		logic            scl_oen;
		logic            sda_oen;
		logic            awready;
		logic            wready;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            arready;
		logic            rvalid;
		logic [1:0]      rresp;
		logic [31:0]     rdata;
	} cbs_host_type;
endpackage : cbs_pkg

/* hw/cbs_smb_if.sv */
// Open-drain SMBus wires joining the host end and the device end.
interface cbs_smb_if;
	logic scl_h_o;
	logic scl_h_oen;
	logic sda_h_o;
	logic sda_h_oen;
	logic sda_d_o;
	logic sda_d_oen;
	logic scl;
	logic sda;

	// Released lines float high; any enabled driver pulls its value.
	assign scl = scl_h_oen ? 1'b1 : scl_h_o;
	assign sda = (sda_h_oen ? 1'b1 : sda_h_o) & (sda_d_oen ? 1'b1 : sda_d_o);

	modport host (output scl_h_o, output scl_h_oen, output sda_h_o, output sda_h_oen,
		input scl, input sda);
	modport dev (output sda_d_o, output sda_d_oen, input scl, input sda);
endinterface : cbs_smb_if

/* hw/cbs_sync.sv */
// Three-stage input synchroniser that accepts a change once stages two and three agree.
module cbs_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rstn,
	// Data
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} cbs_sync_type;

	cbs_sync_type r_r;
	cbs_sync_type r_nxt;
	logic [W-1:0] q_nxt;

	for (genvar g = 0; g < W; g++) begin : g_bit
		assign q_nxt[g] = (r_r.s2[g] == r_r.s3[g]) ? r_r.s3[g] : r_r.q[g];
	end

	always_comb begin
		r_nxt    = r_r;
		r_nxt.s1 = i_d;
		r_nxt.s2 = r_r.s1;
		r_nxt.s3 = r_r.s2;
		r_nxt.q  = q_nxt;
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			r_r <= '1;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign o_q = r_r.q;
endmodule : cbs_sync

/* hw/cbs_dev.sv */
// Device end: SMBus slave holding the configuration and identification bytes.
// Summary of operation
// - Device acks its own write address.
// - Second byte sets the starting register index.
// - Device acks the block write count byte.
// - Data bytes stored at successive indices, acked.
// - Read address after repeated start is acked.
// - Read returns count byte, then registers onward.
// - Host acks bytes, nacks last, then stops.
// - Register 0 bits 7:6 show latched mode.
// - Register 0 bit 3 picks software mode.
// - Bits 2:1 override mode when selected.
// - Readback keeps the latched pin mode.
// - System warm-resets before relying on mode.
// - Software mode bits writable, reset to ones.
// - Output enable zero forces pair low.
// - Identification registers five and six read-only.
// - Register 7 count field resets to eight.
// - Input clock must run for bus access.
`include "cbs_cfg.svh"

module cbs_dev (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	// Start-up strap
	input  wire logic       i_pwrgd,
	input  wire logic [1:0] i_pll_pin,
	// Clock path controls
	output logic      [1:0] o_pll_mode,
	output logic      [5:0] o_out_enable,
	// Serial link
	cbs_smb_if.dev          bus
);
	import cbs_pkg::*;

	// ***************************************************************
	// Pin synchronisers
	// ***************************************************************
	logic [4:0]  sy;
	cbs_dev_type r_r;
	cbs_dev_type r_nxt;
	logic        rise;
	logic        fall;
	logic        start;
	logic        stop;
	logic        ack;
	logic [7:0]  rbyte;

	// The strap inputs enter inverted, so the all-ones reset of the synchroniser
	// reads as power not yet good and cannot latch a false mode.
	cbs_sync #(.W(5)) u_sync (
		.i_clk  (i_clk),
		.i_rstn (i_rstn),
		.i_d    ({~i_pll_pin, ~i_pwrgd, bus.sda, bus.scl}),
		.o_q    (sy)
	);

	// ***************************************************************
	// Register read mux
	// ***************************************************************
	function automatic logic [7:0] cbs_rd(input cbs_dev_type s, input logic [7:0] a);
		logic [7:0] v;
		v = `CBS_RSVD_ZERO;
		case (a)
			`CBS_REG_PLL: begin
				v = `CBS_R0_RSVD | {s.lat_mode, 6'h00};
				v[`CBS_SW_EN_BIT] = s.sw_en;
				v[2:1] = s.sw_mode;
			end
			`CBS_REG_OE_LO: begin
				v = `CBS_R1_RSVD | {1'b0, s.oe[3:2], 2'h0, s.oe[1:0], 1'b0};
			end
			`CBS_REG_OE_HI: v = `CBS_R2_RSVD | {5'h00, s.oe[5:4], 1'b0};
			`CBS_REG_ID:    v = {`CBS_REV_CODE, `CBS_VEN_CODE};
			`CBS_REG_DEV:   v = `CBS_DEV_CODE;
			`CBS_REG_BC:    v = {3'h0, s.bc};
			default:        v = `CBS_RSVD_ZERO;
		endcase
		return v;
	endfunction : cbs_rd

	// ***************************************************************
	// Protocol engine
	// ***************************************************************
	always_comb begin
		r_nxt       = r_r;
		ack         = 1'b1;
		rbyte       = cbs_rd(r_r, r_r.idx);
		rise        = sy[0] & ~r_r.scl_p;
		fall        = ~sy[0] & r_r.scl_p;
		start       = sy[0] & r_r.scl_p & r_r.sda_p & ~sy[1];
		stop        = sy[0] & r_r.scl_p & ~r_r.sda_p & sy[1];
		r_nxt.scl_p = sy[0];
		r_nxt.sda_p = sy[1];
		if (!sy[2] && !r_r.latched) begin
			r_nxt.latched  = 1'b1;
			r_nxt.lat_mode = ~sy[4:3];
		end
		case (r_r.st)
			D_IDLE: begin
			end
			D_RX: begin
				if (rise) begin
					r_nxt.sh  = {r_r.sh[6:0], sy[1]};
					r_nxt.cnt = r_r.cnt + 4'h1;
				end
				if (fall && r_r.cnt == 4'h8) begin
					case (r_r.phase)
						2'h0: begin
							ack      = (r_r.sh[7:1] == `CBS_SLV_ADDR);
							r_nxt.rd = r_r.sh[0];
						end
						2'h1: r_nxt.idx = r_r.sh;
						2'h2: begin
						end
						default: begin
							r_nxt.idx = r_r.idx + 8'h01;
							case (r_r.idx)
								`CBS_REG_PLL: begin
									r_nxt.sw_en   = r_r.sh[`CBS_SW_EN_BIT];
									r_nxt.sw_mode = r_r.sh[2:1];
								end
								`CBS_REG_OE_LO: begin
									r_nxt.oe[1:0] = r_r.sh[2:1];
									r_nxt.oe[3:2] = r_r.sh[6:5];
								end
								`CBS_REG_OE_HI: r_nxt.oe[5:4] = r_r.sh[2:1];
								`CBS_REG_BC:    r_nxt.bc = r_r.sh[4:0];
								default: begin
								end
							endcase
						end
					endcase
					if (ack) begin
						r_nxt.sda_oen = 1'b0;
						r_nxt.st      = D_RACK;
					end else begin
						r_nxt.st = D_IDLE;
					end
				end
			end
			D_RACK: begin
				if (fall) begin
					r_nxt.sda_oen = 1'b1;
					r_nxt.cnt     = 4'h0;
					if (r_r.rd && r_r.phase == 2'h0) begin
						r_nxt.sh      = {3'h0, r_r.bc};
						r_nxt.sda_oen = 1'b0;
						r_nxt.st      = D_TX;
					end else begin
						r_nxt.st = D_RX;
						if (r_r.phase != 2'h3) begin
							r_nxt.phase = r_r.phase + 2'h1;
						end
					end
				end
			end
			D_TX: begin
				if (fall) begin
					if (r_r.cnt == 4'h7) begin
						r_nxt.sda_oen = 1'b1;
						r_nxt.st      = D_TACK;
					end else begin
						r_nxt.cnt     = r_r.cnt + 4'h1;
						r_nxt.sh      = {r_r.sh[6:0], 1'b0};
						r_nxt.sda_oen = r_r.sh[6];
					end
				end
			end
			D_TACK: begin
				if (rise) begin
					r_nxt.mack = ~sy[1];
				end
				if (fall) begin
					if (r_r.mack) begin
						r_nxt.sh      = rbyte;
						r_nxt.sda_oen = rbyte[7];
						r_nxt.idx     = r_r.idx + 8'h01;
						r_nxt.cnt     = 4'h0;
						r_nxt.st      = D_TX;
					end else begin
						r_nxt.st = D_IDLE;
					end
				end
			end
			default: r_nxt.st = D_IDLE;
		endcase
		if (start) begin
			r_nxt.st      = D_RX;
			r_nxt.cnt     = 4'h0;
			r_nxt.phase   = 2'h0;
			r_nxt.sda_oen = 1'b1;
		end else if (stop) begin
			r_nxt.st      = D_IDLE;
			r_nxt.sda_oen = 1'b1;
		end
		r_nxt.pll_mode = r_r.sw_en ? r_r.sw_mode : r_r.lat_mode;
		r_nxt.out_en   = r_r.oe;
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			r_r          <= '0;
			r_r.st       <= D_IDLE;
			r_r.scl_p    <= 1'b1;
			r_r.sda_p    <= 1'b1;
			r_r.sda_oen  <= 1'b1;
			r_r.sw_en    <= `CBS_SW_EN_RST;
			r_r.sw_mode  <= `CBS_SW_MODE_RST;
			r_r.oe       <= `CBS_OE_RST;
			r_r.bc       <= `CBS_BC_RST;
			r_r.lat_mode <= `CBS_MODE_RST;
			r_r.pll_mode <= `CBS_MODE_RST;
			r_r.out_en   <= `CBS_OE_RST;
		end else begin
			r_r <= r_nxt;
		end
	end

	// ***************************************************************
	// Outputs
	// ***************************************************************
	assign o_pll_mode    = r_r.pll_mode;
	assign o_out_enable  = r_r.out_en;
	assign bus.sda_d_o   = r_r.sda_o;
	assign bus.sda_d_oen = r_r.sda_oen;
endmodule : cbs_dev

/* hw/cbs_host.sv */
// Host end: AXI4-Lite command registers driving SMBus block writes and reads.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`include "cbs_cfg.svh"

module cbs_host (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	// AXI4-Lite write
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	output logic      [1:0]  o_bresp,
	// AXI4-Lite read
	input  wire logic        i_arvalid,
	output logic             o_arready,
	input  wire logic [7:0]  i_araddr,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic      [31:0] o_rdata,
	output logic      [1:0]  o_rresp,
	// Serial link
	cbs_smb_if.host          bus
);
	import cbs_pkg::*;

	localparam logic [7:0] QTR_LAST = 8'(`CBS_QTR - 1);

	cbs_host_type r_r;
	cbs_host_type r_nxt;
	logic         sda_s;
	logic         tick;
	logic         rx;
	logic         last;

	cbs_sync #(.W(1)) u_sync (
		.i_clk  (i_clk),
		.i_rstn (i_rstn),
		.i_d    (bus.sda),
		.o_q    (sda_s)
	);

	// Byte sent in slot n of the current transfer.
	function automatic logic [7:0] cbs_tx(input cbs_host_type s, input logic [5:0] n);
		logic [5:0] k;
		k = n - 6'h3;
		if (s.rdph || n == 6'h0) begin
			return {`CBS_SLV_ADDR, s.rdph};
		end else if (n == 6'h1) begin
			return s.idx;
		end else if (n == 6'h2) begin
			return {3'h0, s.cnt};
		end
		return s.buf_d[k[3:0]];
	endfunction : cbs_tx

	always_comb begin
		r_nxt         = r_r;
		rx            = r_r.rdph && r_r.bno != 6'h0;
		last          = (r_r.bno == {1'b0, r_r.cnt} + 6'h1) || r_r.cnt == 5'h00;
		tick          = (r_r.qc == QTR_LAST);
		// ***************************************************************
		// AXI4-Lite slave
		// ***************************************************************
		r_nxt.awready = 1'b0;
		r_nxt.wready  = 1'b0;
		r_nxt.arready = 1'b0;
		if (r_r.awready) begin
			r_nxt.bvalid = 1'b1;
		end else if (r_r.bvalid && i_bready) begin
			r_nxt.bvalid = 1'b0;
		end else if (!r_r.bvalid && i_awvalid && i_wvalid) begin
			r_nxt.awready = 1'b1;
			r_nxt.wready  = 1'b1;
			r_nxt.bresp   = `CBS_OKAY;
			if (i_awaddr == `CBS_H_CTRL) begin
				if (!r_r.busy && |i_wstrb) begin
					r_nxt.rd  = i_wdata[1];
					r_nxt.idx = i_wdata[15:8];
					r_nxt.cnt = i_wdata[20:16];
					if (i_wdata[0]) begin
						r_nxt.busy = 1'b1;
						r_nxt.err  = 1'b0;
						r_nxt.st   = H_START;
						r_nxt.q    = 2'h0;
						r_nxt.qc   = 8'h00;
						r_nxt.bno  = 6'h0;
						r_nxt.rdph = 1'b0;
					end
				end
			end else if (i_awaddr[7:6] == `CBS_H_DATA && i_awaddr[1:0] == 2'h0) begin
				if (i_wstrb[0]) begin
					r_nxt.buf_d[i_awaddr[5:2]] = i_wdata[7:0];
				end
			end else if (i_awaddr != `CBS_H_STAT) begin
				r_nxt.bresp = `CBS_SLVERR;
			end
		end
		if (r_r.arready) begin
			r_nxt.rvalid = 1'b1;
		end else if (r_r.rvalid && i_rready) begin
			r_nxt.rvalid = 1'b0;
		end else if (!r_r.rvalid && i_arvalid) begin
			r_nxt.arready = 1'b1;
			r_nxt.rresp   = `CBS_OKAY;
			r_nxt.rdata   = 32'h0000_0000;
			if (i_araddr == `CBS_H_CTRL) begin
				r_nxt.rdata = {11'h000, r_r.cnt, r_r.idx, 6'h00, r_r.rd, 1'b0};
			end else if (i_araddr == `CBS_H_STAT) begin
				r_nxt.rdata = {16'h0000, r_r.bcnt_rx, 6'h00, r_r.err, r_r.busy};
			end else if (i_araddr[7:6] == `CBS_H_DATA && i_araddr[1:0] == 2'h0) begin
				r_nxt.rdata = {24'h000000, r_r.buf_d[i_araddr[5:2]]};
			end else begin
				r_nxt.rresp = `CBS_SLVERR;
			end
		end
		// ***************************************************************
		// Link sequencer, one step per quarter bit period
		// ***************************************************************
		if (r_r.st != H_IDLE) begin
			r_nxt.qc = tick ? 8'h00 : r_r.qc + 8'h01;
		end
		if (tick) begin
			r_nxt.q = r_r.q + 2'h1;
			case (r_r.st)
				H_START: begin
					case (r_r.q)
						2'h0: r_nxt.sda_oen = 1'b1;
						2'h1: r_nxt.scl_oen = 1'b1;
						2'h2: r_nxt.sda_oen = 1'b0;
						default: begin
							r_nxt.scl_oen = 1'b0;
							r_nxt.st      = H_BIT;
							r_nxt.bitn    = 4'h0;
							r_nxt.sh      = cbs_tx(r_r, r_r.bno);
						end
					endcase
				end
				H_BIT: begin
					case (r_r.q)
						2'h0: begin
							if (r_r.bitn != 4'h8) begin
								r_nxt.sda_oen = rx | r_r.sh[7];
							end else begin
								r_nxt.sda_oen = ~rx | last;
							end
						end
						2'h1: r_nxt.scl_oen = 1'b1;
						2'h2: begin
							if (r_r.bitn != 4'h8 && rx) begin
								r_nxt.sh = {r_r.sh[6:0], sda_s};
							end else if (r_r.bitn == 4'h8 && !rx) begin
								r_nxt.nack = sda_s;
							end
						end
						default: begin
							r_nxt.scl_oen = 1'b0;
							r_nxt.bitn    = 4'h0;
							if (r_r.bitn != 4'h8) begin
								r_nxt.bitn = r_r.bitn + 4'h1;
								if (!rx) begin
									r_nxt.sh = {r_r.sh[6:0], 1'b0};
								end
							end else if (rx) begin
								if (r_r.bno == 6'h1) begin
									r_nxt.bcnt_rx = r_r.sh;
								end else begin
									r_nxt.buf_d[4'(r_r.bno - 6'h2)] = r_r.sh;
								end
								r_nxt.bno = r_r.bno + 6'h1;
								if (last) begin
									r_nxt.st = H_STOP;
								end
							end else if (r_r.nack) begin
								r_nxt.err = 1'b1;
								r_nxt.st  = H_STOP;
							end else if (!r_r.rdph && r_r.rd && r_r.bno == 6'h1) begin
								r_nxt.rdph = 1'b1;
								r_nxt.bno  = 6'h0;
								r_nxt.st   = H_START;
							end else if (!r_r.rdph && r_r.bno == {1'b0, r_r.cnt} + 6'h2) begin
								r_nxt.st = H_STOP;
							end else begin
								r_nxt.bno = r_r.bno + 6'h1;
								r_nxt.sh  = cbs_tx(r_r, r_r.bno + 6'h1);
							end
						end
					endcase
				end
				H_STOP: begin
					case (r_r.q)
						2'h0: r_nxt.sda_oen = 1'b0;
						2'h1: r_nxt.scl_oen = 1'b1;
						2'h2: r_nxt.sda_oen = 1'b1;
						default: begin
							r_nxt.st   = H_IDLE;
							r_nxt.busy = 1'b0;
						end
					endcase
				end
				default: r_nxt.st = H_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			r_r         <= '0;
			r_r.st      <= H_IDLE;
			r_r.scl_oen <= 1'b1;
			r_r.sda_oen <= 1'b1;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign o_awready     = r_r.awready;
	assign o_wready      = r_r.wready;
	assign o_bvalid      = r_r.bvalid;
	assign o_bresp       = r_r.bresp;
	assign o_arready     = r_r.arready;
	assign o_rvalid      = r_r.rvalid;
	assign o_rdata       = r_r.rdata;
	assign o_rresp       = r_r.rresp;
	assign bus.scl_h_o   = r_r.scl_o;
	assign bus.scl_h_oen = r_r.scl_oen;
	assign bus.sda_h_o   = r_r.scl_o;
	assign bus.sda_h_oen = r_r.sda_oen;
endmodule : cbs_host

/* test/cbs_smb_sva.sv */
// Assertions on the open-drain wires between the host end and the device end.
`include "cbs_cfg.svh"

module cbs_smb_sva (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rstn,
	// Link wires
	input  wire logic scl_h_o,
	input  wire logic scl_h_oen,
	input  wire logic sda_h_o,
	input  wire logic sda_h_oen,
	input  wire logic sda_d_o,
	input  wire logic sda_d_oen,
	input  wire logic scl,
	input  wire logic sda
);
	localparam int QTR = `CBS_QTR;
	logic [15:0] lo_cnt_r;
	logic [15:0] hi_cnt_r;

	// ************
	// Phase counters
	// ************
	// Both saturate so that a long idle spell never wraps into a short one.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lo_cnt_r <= 16'h0000;
			hi_cnt_r <= 16'h0000;
		end else begin
			lo_cnt_r <= scl ? 16'h0000 : lo_cnt_r + {15'h0000, lo_cnt_r != 16'hFFFF};
			hi_cnt_r <= !scl ? 16'h0000 : hi_cnt_r + {15'h0000, hi_cnt_r != 16'hFFFF};
		end
	end

	// ************
	// Properties
	// ************
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	property p_drv_low;
		(scl_h_oen || (!scl_h_o && !scl)) && (sda_h_oen || (!sda_h_o && !sda))
			&& (sda_d_oen || (!sda_d_o && !sda));
	endproperty
	a_drv_low: assert property (p_drv_low)
		else $error("An enabled line driver does not pull low.");
	property p_dev_edge;
		$changed(sda_d_oen) |-> !scl && lo_cnt_r >= 16'h0001 && lo_cnt_r <= 16'h0010;
	endproperty
	a_dev_edge: assert property (p_dev_edge)
		else $error("Device changed its data line away from a clock fall.");
	property p_start_host;
		$fell(sda) && scl |-> !sda_h_oen && sda_d_oen;
	endproperty
	a_start_host: assert property (p_start_host)
		else $error("Start condition not made by the host alone.");
	property p_stop_host;
		$rose(sda) && scl |-> $past(sda_h_oen) == 1'b0 && sda_d_oen;
	endproperty
	a_stop_host: assert property (p_stop_host)
		else $error("Stop condition not made by the host release.");
	property p_ack_free;
		scl && !sda_d_oen |-> sda_h_oen;
	endproperty
	a_ack_free: assert property (p_ack_free)
		else $error("Host drives data while the device answers.");
	property p_hi_min;
		$fell(scl) |-> hi_cnt_r >= 2 * QTR - 4;
	endproperty
	a_hi_min: assert property (p_hi_min)
		else $error("Clock high phase shorter than two quarters.");
	property p_lo_min;
		$rose(scl) |-> lo_cnt_r >= QTR / 2;
	endproperty
	a_lo_min: assert property (p_lo_min)
		else $error("Clock low phase too short.");
	property p_host_setup;
		$changed(sda_h_oen) && !scl |-> lo_cnt_r >= QTR / 2;
	endproperty
	a_host_setup: assert property (p_host_setup)
		else $error("Host changed data too soon after a clock fall.");

	c_start: cover property ($fell(sda) && scl);
	c_dev_ack: cover property (scl && !sda_d_oen);
	c_host_low: cover property (scl && $past(scl) && !sda_h_oen);
endmodule : cbs_smb_sva

/* test/testbench.sv */
// Self-checking bench joining both ends of the configuration link.
`include "cbs_cfg.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        i_clk, i_rstn, i_pwrgd, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [7:0]  i_awaddr, i_araddr, d0, d1;
	logic [31:0] i_wdata, o_rdata, rd;
	logic [3:0]  i_wstrb;
	logic [1:0]  o_bresp, o_rresp, i_pll_pin, o_pll_mode, pin0, sw;
	logic [1:0]  modes [3];
	logic [5:0]  o_out_enable;
	logic [65:0] exp_r [$];
	logic [65:0] ent;
	logic [1:0]  exp_b [$];
	int          err_count = 0;
	int          tests_run = 0;
	int          cyc = 0;

	cbs_smb_if i_cbs_smb_if ();
	cbs_host i_cbs_host (.i_clk(i_clk), .i_rstn(i_rstn), .i_awvalid(i_awvalid),
		.o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready),
		.i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready),
		.o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
		.o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
		.bus(i_cbs_smb_if));
	cbs_dev i_cbs_dev (.i_clk(i_clk), .i_rstn(i_rstn), .i_pwrgd(i_pwrgd), .i_pll_pin(i_pll_pin),
		.o_pll_mode(o_pll_mode), .o_out_enable(o_out_enable), .bus(i_cbs_smb_if));
	cbs_smb_sva i_cbs_smb_sva (.i_clk(i_clk), .i_rstn(i_rstn), .scl_h_o(i_cbs_smb_if.scl_h_o),
		.scl_h_oen(i_cbs_smb_if.scl_h_oen), .sda_h_o(i_cbs_smb_if.sda_h_o),
		.sda_h_oen(i_cbs_smb_if.sda_h_oen), .sda_d_o(i_cbs_smb_if.sda_d_o),
		.sda_d_oen(i_cbs_smb_if.sda_d_oen), .scl(i_cbs_smb_if.scl), .sda(i_cbs_smb_if.sda));

	// ************
	// Tasks
	// ************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic close_out();
		$display("Checks run %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge i_clk);
		exp_b.push_back(r);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do begin
			@(posedge i_clk);
			if (o_awready === 1'b1) i_awvalid <= 1'b0;
			if (o_wready === 1'b1) i_wvalid <= 1'b0;
		end while (o_bvalid !== 1'b1);
		i_bready <= 1'b0;
	endtask : axi_wr

	// The mask selects the read data bits that are compared.
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] r);
		@(posedge i_clk);
		exp_r.push_back({m, e & m, r});
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do begin
			@(posedge i_clk);
			if (o_arready === 1'b1) i_arvalid <= 1'b0;
		end while (o_rvalid !== 1'b1);
		rd = o_rdata;
		i_rready <= 1'b0;
	endtask : axi_rd

	task automatic poll();
		do axi_rd(`CBS_H_STAT, 32'h0, 32'h0, `CBS_OKAY);
		while (rd[0] !== 1'b0);
	endtask : poll

	// ************
	// Clock, response watcher and timeout
	// ************
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		if (o_rvalid === 1'b1 && i_rready === 1'b1) begin
			ent = exp_r.pop_front();
			if (ent[65:34] != 32'h0) chk("rdata", ent[33:2], o_rdata & ent[65:34]);
			chk("rresp", {30'h0, ent[1:0]}, {30'h0, o_rresp});
		end
		if (o_bvalid === 1'b1 && i_bready === 1'b1) chk("bresp", {30'h0, exp_b.pop_front()},
			{30'h0, o_bresp});
	end

	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 100000) begin
			err_count++;
			close_out();
		end
	end

	// ************
	// Main sequence
	// ************
	initial begin
		{i_rstn, i_pwrgd, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 7'h00;
		{i_awaddr, i_araddr, i_wdata} = 48'h0;
		i_wstrb = 4'hF;
		modes = '{`CBS_MODE_LOBW, `CBS_MODE_BYP, `CBS_MODE_HIBW};
		void'($urandom(97755));
		pin0 = modes[$urandom_range(2, 0)];
		sw = modes[$urandom_range(2, 0)];
		d0 = 8'($urandom);
		d0[3:1] = {1'b1, sw};
		d1 = 8'($urandom);
		d1[1] = 1'b0;
		i_pll_pin = pin0;
		repeat (2) @(posedge i_clk);
		i_rstn <= 1'b1;
		@(posedge i_clk);
		chk("out_enable", 32'h3F, {26'h0, o_out_enable});
		i_pwrgd <= 1'b1;
		repeat (12) @(posedge i_clk);
		chk("pll_mode", {30'h0, pin0}, {30'h0, o_pll_mode});
		i_pll_pin <= (pin0 == `CBS_MODE_LOBW) ? `CBS_MODE_HIBW : `CBS_MODE_LOBW;
		axi_wr(8'h20, 32'h0, `CBS_SLVERR);
		axi_rd(8'h24, 32'h0, 32'hFFFFFFFF, `CBS_SLVERR);
		chk("pll_mode", {30'h0, pin0}, {30'h0, o_pll_mode});
		axi_wr(8'h40, {24'h0, d0}, `CBS_OKAY);
		axi_wr(8'h44, {24'h0, d1}, `CBS_OKAY);
		axi_wr(`CBS_H_CTRL, 32'h0002_0001, `CBS_OKAY);
		poll();
		axi_rd(`CBS_H_STAT, 32'h0, 32'h3, `CBS_OKAY);
		chk("pll_mode", {30'h0, sw}, {30'h0, o_pll_mode});
		chk("out_enable", {26'h0, 2'b11, d1[6], d1[5], d1[2], d1[1]},
			{26'h0, o_out_enable});
		axi_wr(`CBS_H_CTRL, 32'h0001_0003, `CBS_OKAY);
		poll();
		axi_rd(`CBS_H_STAT, 32'h0000_0800, 32'h0000_FF03, `CBS_OKAY);
		axi_rd(8'h40, {24'h0, pin0, 3'b001, sw, 1'b1}, 32'hFF, `CBS_OKAY);
		// A warm reset drops the software mode and latches the present pin again.
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rstn <= 1'b1;
		@(posedge i_clk);
		chk("pll_mode", {30'h0, `CBS_MODE_RST}, {30'h0, o_pll_mode});
		chk("out_enable", 32'h3F, {26'h0, o_out_enable});
		repeat (12) @(posedge i_clk);
		chk("pll_mode", {30'h0, i_pll_pin}, {30'h0, o_pll_mode});
		close_out();
	end
endmodule : testbench
